/* inc/bcw_pkg.sv */
// board control, watchdog and fan monitor: shared constants
// assumes a 100 MHz system clock and a byte-wide register port
package bcw_pkg;

   // ************************************************************
   // register addresses (primary base and alternate base)
   // ************************************************************
   localparam logic [11:0] ADDR_CTL_PRI = 12'hca2;
   localparam logic [11:0] ADDR_CTL_ALT = 12'hc92;
   localparam logic [11:0] ADDR_WDT_PRI = 12'hca3;
   localparam logic [11:0] ADDR_WDT_ALT = 12'hc93;
   localparam logic [11:0] ADDR_FAN_PRI = 12'hca4;
   localparam logic [11:0] ADDR_FAN_ALT = 12'hc94;
   localparam logic [11:0] ADDR_IST_PRI = 12'hca5;
   localparam logic [11:0] ADDR_IST_ALT = 12'hc95;
   localparam logic [11:0] ADDR_IMK_PRI = 12'hca6;
   localparam logic [11:0] ADDR_IMK_ALT = 12'hc96;

   // ************************************************************
   // special board control fields
   // ************************************************************
   localparam int CTL_JUMPER_BIT = 7;
   localparam int CTL_OVERRIDE_BIT = 6;
   localparam int CTL_CHOICE_BIT = 5;
   localparam int CTL_MODE_HI = 4;
   localparam int CTL_MODE_LO = 3;
   localparam int CTL_EXPIRED_BIT = 2;
   localparam int CTL_RSTEN_BIT = 1;

   // ************************************************************
   // fan monitor fields and interrupt status bits
   // ************************************************************
   localparam int FAN_SLOW_BIT = 7;
   localparam int FAN_IRQEN_BIT = 0;
   localparam int IST_WDT_BIT = 0;
   localparam int IST_FAN_BIT = 1;
   localparam int IST_WIDTH = 2;

   // ************************************************************
   // reset values and watchdog refresh key
   // ************************************************************
   localparam logic RST_OVERRIDE = 1'b0;
   localparam logic RST_CHOICE = 1'b1;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic RST_RSTEN = 1'b0;
   localparam logic RST_FAN_IRQEN = 1'b0;
   localparam logic [IST_WIDTH-1:0] RST_MASK = 2'h0;
   localparam logic [7:0] WDT_REFRESH_KEY = 8'h5a;

   // ************************************************************
   // serial line modes
   // ************************************************************
   localparam logic [1:0] MODE_RS232 = 2'h0;
   localparam logic [1:0] MODE_RS422 = 2'h1;
   localparam logic [1:0] MODE_RS485 = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h3;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_KHZ = 100000;
   localparam int WDT_TIMEOUT_MS = 1000;
   localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * CLK_KHZ;
   localparam int FAN_MIN_HZ = 1;
   localparam int FAN_WINDOW_CYC = (CLK_KHZ * 1000) / FAN_MIN_HZ;

endpackage : bcw_pkg

/* rtl/bcw_sync3.sv */
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to ref_clk_in; reset value is zero
`timescale 1ns/1ns
module bcw_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in, // system clock
   input wire logic resetn_in, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // pins from outside
   output logic [WIDTH-1:0] level_out // filtered level
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] level_nxt;

   // only s2 and s3 are looked at; s1 may be metastable
   assign agree = ~(s2_r ^ s3_r);
   assign level_nxt = (agree & s3_r) | (~agree & level_out);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level_out <= '0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_out <= level_nxt;
      end
   end

endmodule : bcw_sync3

/* rtl/bcw_regs.sv */
// board control register group: image select, serial mode, watchdog, fan
// assumes the byte register port and pins synchronised by bcw_sync3
//
// Contract
// R1 - D7 reads jumper: 0 fitted, 1 absent
// R2 - override set: choice bit picks image
// R3 - choice 0 backup, 1 primary
// R4 - mode field: 232, 422, 485, off
// R5 - D2 reads watchdog expired
// R6 - D1 enables watchdog reset output
// R7 - D0 of control reserved
// R8 - write 5Ah to refresh restarts timeout
// R9 - software refreshes faster than 1000 ms
// R10 - fan flag 1 below 1 Hz
// R11 - fan D0 enables fan interrupt
// R12 - fan D6-D1 reserved
// R13 - control at CA2h or C92h, byte access
// R14 - timeout sets expiry, resets if enabled
// R15 - fan irq while slow and enabled
`timescale 1ns/1ns
module bcw_regs #(
   parameter bit ALT_BASE = 1'b0,
   parameter int WDT_CYCLES = bcw_pkg::WDT_TIMEOUT_CYC,
   parameter int FAN_CYCLES = bcw_pkg::FAN_WINDOW_CYC
) (
   input wire logic ref_clk_in, // 100 MHz system clock
   input wire logic resetn_in, // async reset, active low
   input wire logic [11:0] addr_in, // register address
   input wire logic [7:0] wdata_in, // write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [7:0] rdata_out, // read data, cycle after rd_in
   input wire logic jumper_absent_in, // selector pin, high when no jumper
   input wire logic fan_tach_in, // fan tachometer pin
   output logic image_primary_out, // 1 primary image, 0 backup
   output logic [1:0] serial_line_mode_out, // serial transceiver mode
   output logic serial_enable_out, // serial port enabled
   output logic sys_reset_out, // watchdog system reset request
   output logic fan_irq_out, // fan interrupt line
   output logic irq_out // summary interrupt, level
);

   // ************************************************************
   // address decode
   // ************************************************************
   wire sel_ctl = addr_in == (ALT_BASE ? bcw_pkg::ADDR_CTL_ALT : bcw_pkg::ADDR_CTL_PRI);
   wire sel_wdt = addr_in == (ALT_BASE ? bcw_pkg::ADDR_WDT_ALT : bcw_pkg::ADDR_WDT_PRI);
   wire sel_fan = addr_in == (ALT_BASE ? bcw_pkg::ADDR_FAN_ALT : bcw_pkg::ADDR_FAN_PRI);
   wire sel_ist = addr_in == (ALT_BASE ? bcw_pkg::ADDR_IST_ALT : bcw_pkg::ADDR_IST_PRI);
   wire sel_imk = addr_in == (ALT_BASE ? bcw_pkg::ADDR_IMK_ALT : bcw_pkg::ADDR_IMK_PRI);
   wire wr_ctl = wr_in & sel_ctl; // R13
   wire wr_fan = wr_in & sel_fan;
   wire wr_ist = wr_in & sel_ist;
   wire wr_imk = wr_in & sel_imk;
   wire refresh = wr_in & sel_wdt & (wdata_in == bcw_pkg::WDT_REFRESH_KEY); // R8

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [1:0] pins_sync;

   bcw_sync3 #(
      .WIDTH(2)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .async_in({fan_tach_in, jumper_absent_in}),
      .level_out(pins_sync)
   );

   wire jumper_state = pins_sync[0];
   wire tach_level = pins_sync[1];

   // ************************************************************
   // control registers
   // ************************************************************
   logic override_r;
   logic choice_r;
   logic [1:0] mode_r;
   logic rsten_r;
   logic fan_irqen_r;
   logic [bcw_pkg::IST_WIDTH-1:0] mask_r;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         override_r <= bcw_pkg::RST_OVERRIDE;
         choice_r <= bcw_pkg::RST_CHOICE;
         mode_r <= bcw_pkg::RST_MODE;
         rsten_r <= bcw_pkg::RST_RSTEN;
      end else if (wr_ctl) begin
         // jumper and expiry bits are read-only; d0 is dropped
         override_r <= wdata_in[bcw_pkg::CTL_OVERRIDE_BIT]; // R2
         choice_r <= wdata_in[bcw_pkg::CTL_CHOICE_BIT]; // R3
         mode_r <= wdata_in[bcw_pkg::CTL_MODE_HI:bcw_pkg::CTL_MODE_LO]; // R4
         rsten_r <= wdata_in[bcw_pkg::CTL_RSTEN_BIT]; // R6
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fan_irqen_r <= bcw_pkg::RST_FAN_IRQEN;
      end else if (wr_fan) begin
         fan_irqen_r <= wdata_in[bcw_pkg::FAN_IRQEN_BIT]; // R11
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mask_r <= bcw_pkg::RST_MASK;
      end else if (wr_imk) begin
         mask_r <= wdata_in[bcw_pkg::IST_WIDTH-1:0];
      end
   end

   // ************************************************************
   // image select and serial mode
   // ************************************************************
   assign image_primary_out = override_r ? choice_r : jumper_state; // R2 R3
   assign serial_line_mode_out = mode_r; // R4
   assign serial_enable_out = mode_r != bcw_pkg::MODE_OFF; // R4

   // ************************************************************
   // watchdog
   // ************************************************************
   // the count restarts on every timeout so a late refresh still
   // gives a full period before the next expiry
   logic [31:0] wdt_cnt_r;
   logic expired_r;
   wire wdt_timeout = wdt_cnt_r == 32'(WDT_CYCLES - 1);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wdt_cnt_r <= 32'h0;
      end else if (refresh || wdt_timeout) begin
         wdt_cnt_r <= 32'h0; // R8
      end else begin
         wdt_cnt_r <= wdt_cnt_r + 32'h1;
      end
   end

   // expiry wins over a refresh in the same cycle
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         expired_r <= 1'b0;
      end else if (wdt_timeout) begin
         expired_r <= 1'b1; // R14 R5
      end else if (refresh) begin
         expired_r <= 1'b0;
      end
   end

   assign sys_reset_out = expired_r & rsten_r; // R14 R6

   // ************************************************************
   // fan tachometer monitor
   // ************************************************************
   logic tach_prev_r;
   logic [31:0] fan_cnt_r;
   logic slow_r;
   wire tach_rise = tach_level & ~tach_prev_r;
   wire fan_window_end = fan_cnt_r == 32'(FAN_CYCLES - 1);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tach_prev_r <= 1'b0;
         fan_cnt_r <= 32'h0;
         slow_r <= 1'b0;
      end else begin
         tach_prev_r <= tach_level;
         if (tach_rise) begin
            fan_cnt_r <= 32'h0;
            slow_r <= 1'b0; // R10
         end else if (fan_window_end) begin
            slow_r <= 1'b1; // R10
         end else begin
            fan_cnt_r <= fan_cnt_r + 32'h1;
         end
      end
   end

   assign fan_irq_out = slow_r & fan_irqen_r; // R15 R11

   // ************************************************************
   // interrupt status and mask
   // ************************************************************
   logic [bcw_pkg::IST_WIDTH-1:0] ist_r;
   logic slow_prev_r;
   logic [bcw_pkg::IST_WIDTH-1:0] ist_set;
   logic [bcw_pkg::IST_WIDTH-1:0] ist_clr;

   assign ist_set = {slow_r & ~slow_prev_r, wdt_timeout};
   assign ist_clr = wr_ist ? wdata_in[bcw_pkg::IST_WIDTH-1:0] : '0;

   // set beats the write-one clear
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ist_r <= '0;
         slow_prev_r <= 1'b0;
      end else begin
         ist_r <= (ist_r & ~ist_clr) | ist_set;
         slow_prev_r <= slow_r;
      end
   end

   assign irq_out = |(ist_r & mask_r);

   // ************************************************************
   // read path
   // ************************************************************
   logic [7:0] ctl_val;
   logic [7:0] fan_val;
   logic [7:0] rd_mux;

   assign ctl_val = {jumper_state, override_r, choice_r, mode_r, expired_r, rsten_r,
                     1'b0}; // R1 R5 R7
   assign fan_val = {slow_r, 6'h00, fan_irqen_r}; // R10 R12
   assign rd_mux = sel_ctl ? ctl_val :
                   sel_fan ? fan_val :
                   sel_ist ? {6'h00, ist_r} :
                   sel_imk ? {6'h00, mask_r} : 8'h00;

   // data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_in ? rd_mux : 8'h00; // R13
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence seq_ctl_read;
      rd_in && sel_ctl;
   endsequence

   sequence seq_refresh_write;
      wr_in && sel_wdt && wdata_in == bcw_pkg::WDT_REFRESH_KEY;
   endsequence

   AST_JUMPER_READ: assert property (seq_ctl_read |=> rdata_out[7] == $past(jumper_state)) // R1
      else $error("jumper bit read wrong");
   AST_IMAGE_SEL: assert property (image_primary_out ==
      (override_r ? choice_r : jumper_state)) // R2
      else $error("image select wrong");
   AST_CHOICE_WRITE: assert property (wr_ctl && wdata_in[6] |=>
      image_primary_out == $past(wdata_in[5])) // R3
      else $error("choice bit not applied");
   AST_MODE_OFF: assert property (serial_enable_out == (serial_line_mode_out != 2'h3)) // R4
      else $error("serial enable wrong");
   AST_EXPIRE_READ: assert property (seq_ctl_read |=> rdata_out[2] == $past(expired_r)) // R5
      else $error("expiry bit read wrong");
   AST_RESET_EN: assert property (sys_reset_out |-> rsten_r && expired_r) // R6
      else $error("reset without enable");
   AST_RSVD_CTL: assert property (seq_ctl_read |=> rdata_out[0] == 1'b0) // R7
      else $error("reserved bit not zero");
   AST_REFRESH: assert property (seq_refresh_write ##1 !wr_in [*2] |=>
      wdt_cnt_r == 32'h2 || WDT_CYCLES < 3) // R8
      else $error("refresh did not restart");
   AST_TIMEOUT: assert property (wdt_timeout |=> expired_r && wdt_cnt_r == 32'h0) // R14
      else $error("timeout not flagged");
   AST_SLOW: assert property (fan_window_end && !tach_rise |=> slow_r) // R10
      else $error("slow fan not flagged");
   AST_FAN_RSVD: assert property (rd_in && sel_fan |=> rdata_out[6:1] == 6'h00) // R12
      else $error("fan reserved bits set");
   AST_FAN_IRQ: assert property (fan_irq_out == (slow_r && fan_irqen_r)) // R15
      else $error("fan irq wrong");
   AST_UNMAPPED_READ: assert property (rd_in && !(sel_ctl || sel_fan || sel_ist || sel_imk)
      |=> rdata_out == 8'h00) // R13
      else $error("unmapped read not zero");

endmodule : bcw_regs

/* verif/bcw_regs_bench.sv */
// self-checking bench for the board control register group
// assumes bcw_pkg compiled first; short watchdog and fan windows via parameters
`timescale 1ns/1ns
module bcw_regs_bench;
   // ************************************************************
   // stimulus signals and counters
   // ************************************************************
   localparam int WDT_CYC = 200;
   localparam int FAN_CYC = 100;
   localparam logic [11:0] A_CTL = bcw_pkg::ADDR_CTL_PRI;
   localparam logic [11:0] A_WDT = bcw_pkg::ADDR_WDT_PRI;
   localparam logic [11:0] A_FAN = bcw_pkg::ADDR_FAN_PRI;
   localparam logic [11:0] A_IST = bcw_pkg::ADDR_IST_PRI;
   localparam logic [11:0] A_IMK = bcw_pkg::ADDR_IMK_PRI;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic jumper = 1'b1;
   logic tach = 1'b0;
   logic fan_run = 1'b1;
   logic [4:0] tcnt = 5'h00;
   logic [7:0] rdata;
   logic image;
   logic [1:0] mode;
   logic ser_en;
   logic sys_rst;
   logic fan_irq;
   logic irq;
   int n_mismatch = 0;
   int num_checks = 0;

   bcw_regs #(.ALT_BASE(1'b0), .WDT_CYCLES(WDT_CYC), .FAN_CYCLES(FAN_CYC)) uut (
      .ref_clk_in(ref_clk), .resetn_in(resetn), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .jumper_absent_in(jumper),
      .fan_tach_in(tach), .image_primary_out(image), .serial_line_mode_out(mode),
      .serial_enable_out(ser_en), .sys_reset_out(sys_rst), .fan_irq_out(fan_irq),
      .irq_out(irq));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // tach period of 32 cycles, well inside the slow-fan window
   always @(posedge ref_clk) begin
      tcnt <= tcnt + 5'h01;
      if (fan_run) tach <= tcnt[4];
   end

   // ************************************************************
   // bus and compare tasks
   // ************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask : rd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic bit1(input logic seen, input logic exp, input string what);
      check({7'h00, seen}, {7'h00, exp}, what);
   endtask : bit1

   task automatic rd_check(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp,
                           input string what);
      logic [7:0] v;
      rd(a, v);
      check(v & m, exp, what);
   endtask : rd_check

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      rd_check(A_CTL, 8'hff, 8'ha0, "control after reset");
      rd_check(bcw_pkg::ADDR_CTL_ALT, 8'hff, 8'h00, "alternate base unused");
      rd_check(A_FAN, 8'hff, 8'h00, "fan after reset");
      rd_check(A_IMK, 8'hff, 8'h00, "mask after reset");
      rd_check(A_WDT, 8'hff, 8'h00, "refresh reads zero");
      rd_check(12'h123, 8'hff, 8'h00, "unmapped read");
      bit1(irq, 1'b0, "irq after reset");
   endtask : t_reset

   task automatic t_image();
      logic j, o, c;
      for (int i = 0; i < 8; i++) begin
         j = i[0];
         o = i[1];
         c = i[2];
         wr(A_CTL, {~j, o, c, 5'h00});
         @(posedge ref_clk) jumper <= j;
         cyc(6);
         bit1(image, o ? c : j, "image select");
         rd_check(A_CTL, 8'he1, {j, o, c, 5'h00}, "image fields");
      end
   endtask : t_image

   task automatic t_mode();
      for (int m = 0; m < 4; m++) begin
         wr(A_CTL, {3'h0, m[1:0], 3'h1});
         cyc(1);
         check({6'h00, mode}, {6'h00, m[1:0]}, "line mode");
         bit1(ser_en, m != 3, "port enable");
         rd_check(A_CTL, 8'h19, {3'h0, m[1:0], 3'h0}, "mode readback");
      end
   endtask : t_mode

   // refreshes every 150 cycles keep inside the 200-cycle timeout
   task automatic t_wdog();
      wr(A_CTL, 8'h02);
      wr(A_WDT, bcw_pkg::WDT_REFRESH_KEY);
      cyc(150);
      wr(A_WDT, bcw_pkg::WDT_REFRESH_KEY);
      cyc(150);
      rd_check(A_CTL, 8'h06, 8'h02, "refreshed, not expired");
      bit1(sys_rst, 1'b0, "no reset before timeout");
      wr(A_WDT, 8'h5b);
      cyc(80);
      rd_check(A_CTL, 8'h06, 8'h06, "expired after timeout");
      bit1(sys_rst, 1'b1, "reset on timeout");
      rd_check(A_IST, 8'h01, 8'h01, "timeout status");
      bit1(irq, 1'b0, "masked irq");
      wr(A_IMK, 8'h01);
      cyc(1);
      bit1(irq, 1'b1, "unmasked irq");
      wr(A_IST, 8'h01);
      cyc(1);
      bit1(irq, 1'b0, "status cleared");
      wr(A_CTL, 8'h00);
      cyc(1);
      bit1(sys_rst, 1'b0, "reset disabled");
      rd_check(A_CTL, 8'h06, 8'h04, "expired stays");
      wr(A_WDT, bcw_pkg::WDT_REFRESH_KEY);
      rd_check(A_CTL, 8'h04, 8'h00, "refresh clears expiry");
      wr(A_IMK, 8'h00);
   endtask : t_wdog

   task automatic t_fan();
      rd_check(A_FAN, 8'hff, 8'h00, "fan running");
      @(posedge ref_clk) fan_run <= 1'b0;
      cyc(FAN_CYC + 30);
      rd_check(A_FAN, 8'hff, 8'h80, "fan stopped");
      bit1(fan_irq, 1'b0, "fan irq disabled");
      wr(A_FAN, 8'hff);
      cyc(1);
      bit1(fan_irq, 1'b1, "fan irq enabled");
      rd_check(A_FAN, 8'hff, 8'h81, "reserved fan bits");
      rd_check(A_IST, 8'h02, 8'h02, "fan status");
      wr(A_IMK, 8'h02);
      cyc(1);
      bit1(irq, 1'b1, "fan summary irq");
      wr(A_IST, 8'h02);
      cyc(1);
      bit1(irq, 1'b0, "fan status cleared");
      @(posedge ref_clk) fan_run <= 1'b1;
      cyc(60);
      rd_check(A_FAN, 8'hff, 8'h01, "fan recovered");
      bit1(fan_irq, 1'b0, "fan irq drops");
      wr(A_FAN, 8'h00);
      wr(A_IMK, 8'h00);
   endtask : t_fan

   // ************************************************************
   // run control
   // ************************************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      cyc(12);
      resetn <= 1'b1;
      // the pin filter needs four edges before the jumper level shows
      cyc(5);
      t_reset();
      t_image();
      t_mode();
      t_wdog();
      t_fan();
      finish_test();
   end

   // the whole run needs about 760 cycles
   initial begin
      cyc(20000);
      n_mismatch++;
      finish_test();
   end
endmodule : bcw_regs_bench
